// File: pkg/apt_defines.svh
// Purpose: constants of the drive port power and 3-state control
// Assumes: 125 MHz mclk
// Notes:   all offsets, codes and counts live here
// Functional notes
// - after reset the whole drive interface is off, all outputs tri-stated
// - after reset the weak pulldowns are on for every drive-bus line
// - setting drive_bus_disable tri-states the entire drive bus
// - only clearing drive_bus_disable re-enables outputs; setting it again tri-states
// - drive reset buffer off with pulldown until the interface is enabled
// - power indications are open-drain, never driven during reset
// - vbus seen during boot drives low_power_indication low
// - no vbus at boot: leave it undriven; firmware drives both later
// - high_power_indication is driven only under firmware control
// - hard-reset bit set drives drive_reset_out low; clear releases it
// - set hard reset, clear bus disable, clear hard reset after duration
// - in the fully automatic scheme each command block becomes an ordered series of register writes
// - command block length accepted only from 1 to 16 bytes
// - status wrapper echoes the command tag and carries the data residue
// - status stage is never started by hardware, only by firmware
// - three transfer schemes: fully manual, semi-automatic, fully automatic
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH
`define APT_CLK_MHZ        125
`define APT_RST_MIN_NS     25000
`define APT_RST_CYC        ((`APT_RST_MIN_NS * `APT_CLK_MHZ + 999) / 1000)
`define APT_CB_LEN_MIN     5'h01
`define APT_CB_LEN_MAX     5'h10
`define APT_BUS_DIS_RST    1'b1
`define APT_HARD_RST_RST   1'b0
`define APT_PKT_CMD        8'ha0
`define APT_REG_DATA       3'h0
`define APT_REG_FEAT       3'h1
`define APT_REG_SCNT       3'h2
`define APT_REG_SNUM       3'h3
`define APT_REG_CYLL       3'h4
`define APT_REG_CYLH       3'h5
`define APT_REG_DEVH       3'h6
`define APT_REG_CMD        3'h7
`define APT_ATA_STEPS      3'h7
`endif

// File: pkg/apt_pkg.sv
// Purpose: shared types of the drive port control
// Assumes: constants come from apt_defines.svh
// Notes:   none
package apt_pkg;
  typedef enum logic [1:0] {
    SCH_MANUAL,
    SCH_SEMI,
    SCH_AUTO
  } apt_scheme_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] data;
  } apt_dev_wr_t;

  typedef struct packed {
    logic [31:0] tag;
    logic [31:0] residue;
  } apt_csw_t;

  typedef logic [15:0][7:0] apt_task_file_t;
endpackage

// File: hw/apt_sync.sv
// Purpose: three-flop filter for a pin input
// Assumes: pin is asynchronous to mclk
// Notes:   output moves only when the last two stages agree
`timescale 1ns/10ps
module apt_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // pin in, filtered level out
  input  wire logic pinIn,
  output logic      levelOut
);
  logic s1_q, s2_q, s3_q;

  always_ff @(posedge mclk) begin
    s1_q <= pinIn;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      levelOut <= 1'b0;
    end else if (s2_q == s3_q) begin
      levelOut <= s3_q;
    end
  end
endmodule // apt_sync

// File: hw/apt_cmd_seq.sv
// Purpose: turns a task-file command block into drive register writes
// Assumes: one write per cycle while devReady is high
// Notes:   ata and packet orders are fixed
`timescale 1ns/10ps
`include "apt_defines.svh"
module apt_cmd_seq
  import apt_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // request
  input  wire logic           start,
  input  wire logic           isPacket,
  input  wire logic [4:0]     cbLen,
  input  wire apt_task_file_t taskFile,
  input  wire logic           devReady,
  // answer
  output apt_dev_wr_t         devWr_q,
  output logic                busy_q,
  output logic                lenErr_q
);
  logic [3:0] step_q;
  logic [3:0] last_q;

  function automatic logic [10:0] ata_step(input logic [2:0] s);
    // returns {register, task-file index}
    unique case (s)
      3'h0: ata_step = {`APT_REG_DEVH, 8'h06};
      3'h1: ata_step = {`APT_REG_FEAT, 8'h01};
      3'h2: ata_step = {`APT_REG_SCNT, 8'h02};
      3'h3: ata_step = {`APT_REG_SNUM, 8'h03};
      3'h4: ata_step = {`APT_REG_CYLL, 8'h04};
      3'h5: ata_step = {`APT_REG_CYLH, 8'h05};
      default: ata_step = {`APT_REG_CMD, 8'h07};
    endcase
  endfunction

  logic [10:0] ataNow;
  logic [3:0]  wIdx;
  assign ataNow = ata_step(step_q[2:0]);
  assign wIdx   = step_q - 4'h1;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_q   <= 1'b0;
      lenErr_q <= 1'b0;
      step_q   <= 4'h0;
      last_q   <= 4'h0;
    end else if (!busy_q && start) begin
      // odd packet lengths round up to whole words
      lenErr_q <= (cbLen < `APT_CB_LEN_MIN) || (cbLen > `APT_CB_LEN_MAX);
      busy_q   <= (cbLen >= `APT_CB_LEN_MIN) && (cbLen <= `APT_CB_LEN_MAX);
      step_q   <= 4'h0;
      last_q   <= isPacket ? 4'((cbLen + 5'h1) >> 1) : 4'(`APT_ATA_STEPS - 3'h1);
    end else if (busy_q && devReady) begin
      step_q <= step_q + 4'h1;
      busy_q <= (step_q != last_q);
    end
  end

  logic pkt_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pkt_q <= 1'b0;
    end else if (!busy_q && start) begin
      pkt_q <= isPacket;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      devWr_q <= '0;
    end else begin
      devWr_q.wr <= busy_q && devReady;
      if (pkt_q && step_q == 4'h0) begin
        devWr_q.addr <= `APT_REG_CMD;
        devWr_q.data <= {8'h00, `APT_PKT_CMD};
      end else if (pkt_q) begin
        devWr_q.addr <= `APT_REG_DATA;
        devWr_q.data <= {taskFile[{wIdx[2:0], 1'b1}], taskFile[{wIdx[2:0], 1'b0}]};
      end else begin
        devWr_q.addr <= ataNow[10:8];
        devWr_q.data <= {8'h00, taskFile[ataNow[3:0]]};
      end
    end
  end

  property p_len_guard;
    @(posedge mclk) disable iff (!nrst)
      (!busy_q && start && (cbLen == 5'h00 || cbLen > 5'h10)) |=> !busy_q && lenErr_q;
  endproperty
  a_len_guard: assert property (p_len_guard) else $error("bad length accepted");

  property p_ata_first;
    @(posedge mclk) disable iff (!nrst)
      (!busy_q && start && !isPacket && cbLen != 5'h00 && cbLen <= 5'h10) ##1 devReady
        |=> devWr_q.wr && devWr_q.addr == 3'h6;
  endproperty
  a_ata_first: assert property (p_ata_first) else $error("ata order wrong");
endmodule // apt_cmd_seq

// File: hw/apt_port_ctrl.sv
// Purpose: drive port power-up, 3-state and reset sequencing
// Assumes: firmware control bits arrive as one-cycle write strobes
// Notes:   open-drain pins are oe-only; their level is always low
`timescale 1ns/10ps
`include "apt_defines.svh"
module apt_port_ctrl
  import apt_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // vbus pin
  input  wire logic           vbusPin,
  // firmware control strobes
  input  wire logic           busDisWr,
  input  wire logic           busDisVal,
  input  wire logic           hardRstWr,
  input  wire logic           hardRstVal,
  input  wire logic           bootDone,
  input  wire logic           fwLowPwrWr,
  input  wire logic           fwLowPwrVal,
  input  wire logic           fwHighPwrWr,
  input  wire logic           fwHighPwrVal,
  // transfer scheme and command
  input  wire apt_scheme_t    scheme,
  input  wire logic           cmdStart,
  input  wire logic           isPacket,
  input  wire logic [4:0]     cbLen,
  input  wire apt_task_file_t taskFile,
  input  wire logic           devReady,
  // status stage from firmware
  input  wire logic           cswPrepare,
  input  wire logic [31:0]    cbwTag,
  input  wire logic [31:0]    expectedLen,
  input  wire logic [31:0]    processedLen,
  // drive bus pins
  output logic                busOe_q,
  output logic                busPulldown_q,
  output logic                driveRstOut_q,
  output logic                driveRstOe_q,
  output logic                driveRstPd_q,
  // power indication pins
  output logic                lowPwrOut_q,
  output logic                lowPwrOe_q,
  output logic                highPwrOut_q,
  output logic                highPwrOe_q,
  // command writes and status
  output apt_dev_wr_t         devWr_q,
  output logic                cmdBusy_q,
  output logic                cmdLenErr_q,
  output logic                dataAutoEn_q,
  output apt_csw_t            csw_q,
  output logic                cswValid_q,
  output logic                busDisable_q,
  output logic                hardReset_q,
  output logic                orderErr_q,
  output logic                rstTimeMet_q
);
  // ****************************************
  // pin filtering
  // ****************************************
  logic vbusSeen;

  apt_sync u_vbus (
    .mclk     (mclk),
    .nrst     (nrst),
    .pinIn    (vbusPin),
    .levelOut (vbusSeen)
  );

  // ****************************************
  // control bits
  // ****************************************
  // the bus stays off after reset with no firmware action at all
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busDisable_q <= `APT_BUS_DIS_RST;
    end else if (busDisWr) begin
      busDisable_q <= busDisVal;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hardReset_q <= `APT_HARD_RST_RST;
    end else if (hardRstWr) begin
      hardReset_q <= hardRstVal;
    end
  end

  // ****************************************
  // drive bus buffers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busOe_q       <= 1'b0;
      busPulldown_q <= 1'b1;
    end else begin
      busOe_q       <= !busDisable_q;
      busPulldown_q <= busDisable_q;
    end
  end

  // reset pin: pulldown holds it low while its buffer is off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      driveRstOe_q  <= 1'b0;
      driveRstPd_q  <= 1'b1;
      driveRstOut_q <= 1'b0;
    end else begin
      driveRstOe_q  <= !busDisable_q;
      driveRstPd_q  <= busDisable_q;
      driveRstOut_q <= !hardReset_q;
    end
  end

  // ****************************************
  // power indications
  // ****************************************
  logic bootPhase_q;
  logic fwLow_q;
  logic bootLow_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bootPhase_q <= 1'b1;
    end else if (bootDone) begin
      bootPhase_q <= 1'b0;
    end
  end

  // boot drive of the low indication latches once vbus is seen
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bootLow_q <= 1'b0;
    end else if (bootPhase_q && vbusSeen) begin
      bootLow_q <= 1'b1;
    end else if (!bootPhase_q && fwLowPwrWr) begin
      bootLow_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fwLow_q <= 1'b0;
    end else if (!bootPhase_q && fwLowPwrWr) begin
      fwLow_q <= fwLowPwrVal;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lowPwrOe_q   <= 1'b0;
      lowPwrOut_q  <= 1'b0;
      highPwrOe_q  <= 1'b0;
      highPwrOut_q <= 1'b0;
    end else begin
      lowPwrOe_q <= bootLow_q || fwLow_q;
      if (fwHighPwrWr) begin
        highPwrOe_q <= fwHighPwrVal;
      end
    end
  end

  // ****************************************
  // power-up ordering watch
  // ****************************************
  // hardware does not enforce the order; it reports a slip to firmware
  localparam int unsigned RstCyc = `APT_RST_CYC;
  logic [11:0] rstCnt_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rstCnt_q     <= 12'h000;
      rstTimeMet_q <= 1'b0;
    end else if (!hardReset_q || busDisable_q) begin
      rstCnt_q     <= 12'h000;
      rstTimeMet_q <= 1'b0;
    end else if (!rstTimeMet_q) begin
      rstCnt_q     <= rstCnt_q + 12'h001;
      rstTimeMet_q <= (rstCnt_q == 12'(RstCyc - 1));
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      orderErr_q <= 1'b0;
    end else if (busDisWr && !busDisVal && busDisable_q && !hardReset_q) begin
      orderErr_q <= 1'b1;
    end else if (hardRstWr && !hardRstVal && hardReset_q && !rstTimeMet_q) begin
      orderErr_q <= 1'b1;
    end else if (busDisWr && busDisVal) begin
      orderErr_q <= 1'b0;
    end
  end

  // ****************************************
  // command stage
  // ****************************************
  logic autoStart;
  assign autoStart = cmdStart && (scheme == SCH_AUTO) && !busDisable_q;

  apt_cmd_seq u_seq (
    .mclk     (mclk),
    .nrst     (nrst),
    .start    (autoStart),
    .isPacket (isPacket),
    .cbLen    (cbLen),
    .taskFile (taskFile),
    .devReady (devReady && !busDisable_q),
    .devWr_q  (devWr_q),
    .busy_q   (cmdBusy_q),
    .lenErr_q (cmdLenErr_q)
  );

  // data stage automation: semi and full schemes only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dataAutoEn_q <= 1'b0;
    end else begin
      dataAutoEn_q <= (scheme == SCH_SEMI) || (scheme == SCH_AUTO);
    end
  end

  // ****************************************
  // status stage
  // ****************************************
  // built only when firmware asks; no scheme starts it by itself
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      csw_q      <= '0;
      cswValid_q <= 1'b0;
    end else begin
      cswValid_q <= cswPrepare;
      if (cswPrepare) begin
        csw_q.tag     <= cbwTag;
        csw_q.residue <= expectedLen - processedLen;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_reset_tristate;
    @(posedge mclk) nrst && $past(!nrst) |-> !busOe_q && busPulldown_q && !driveRstOe_q;
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) else $error("bus on after reset");

  property p_pulldown;
    @(posedge mclk) disable iff (!nrst) busPulldown_q == !busOe_q;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown mismatch");

  property p_disable;
    @(posedge mclk) disable iff (!nrst) busDisWr && busDisVal |-> ##2 !busOe_q;
  endproperty
  a_disable: assert property (p_disable) else $error("bus not tri-stated");

  property p_enable_cause;
    @(posedge mclk) disable iff (!nrst) $rose(busOe_q) |-> $past(busDisWr, 2) && !busDisable_q;
  endproperty
  a_enable_cause: assert property (p_enable_cause) else $error("bus enabled w/o clear");

  property p_rst_buf;
    @(posedge mclk) disable iff (!nrst) busDisable_q |=> !driveRstOe_q && driveRstPd_q;
  endproperty
  a_rst_buf: assert property (p_rst_buf) else $error("reset buffer on");

  property p_od_reset;
    @(posedge mclk) nrst && $past(!nrst) |-> !lowPwrOe_q && !highPwrOe_q && !lowPwrOut_q;
  endproperty
  a_od_reset: assert property (p_od_reset) else $error("power pin driven in reset");

  property p_vbus_low;
    @(posedge mclk) disable iff (!nrst) bootPhase_q && vbusSeen |-> ##2 lowPwrOe_q;
  endproperty
  a_vbus_low: assert property (p_vbus_low) else $error("low power not driven");

  property p_no_vbus;
    @(posedge mclk) disable iff (!nrst)
      bootPhase_q && !vbusSeen && !bootLow_q ##1 bootPhase_q |=> !lowPwrOe_q;
  endproperty
  a_no_vbus: assert property (p_no_vbus) else $error("low power driven w/o vbus");

  property p_high_fw;
    @(posedge mclk) disable iff (!nrst) $changed(highPwrOe_q) |-> $past(fwHighPwrWr);
  endproperty
  a_high_fw: assert property (p_high_fw) else $error("high power moved by hw");

  property p_hard_rst;
    @(posedge mclk) disable iff (!nrst) hardRstWr && hardRstVal |-> ##2 !driveRstOut_q;
  endproperty
  a_hard_rst: assert property (p_hard_rst) else $error("reset pin not low");

  property p_csw;
    @(posedge mclk) disable iff (!nrst)
      cswPrepare |=> cswValid_q && csw_q.tag == $past(cbwTag)
        && csw_q.residue == $past(expectedLen) - $past(processedLen);
  endproperty
  a_csw: assert property (p_csw) else $error("status wrapper wrong");

  property p_csw_fw;
    @(posedge mclk) disable iff (!nrst) cswValid_q |-> $past(cswPrepare);
  endproperty
  a_csw_fw: assert property (p_csw_fw) else $error("status without firmware");

  property p_seq_auto;
    @(posedge mclk) disable iff (!nrst) $rose(cmdBusy_q) |-> $past(scheme) == SCH_AUTO;
  endproperty
  a_seq_auto: assert property (p_seq_auto) else $error("sequencer outside auto");

  property p_rst_time;
    @(posedge mclk) disable iff (!nrst)
      $rose(rstTimeMet_q) |-> $past(hardReset_q) && !$past(busDisable_q);
  endproperty
  a_rst_time: assert property (p_rst_time) else $error("reset time misjudged");

  c_bus_on:   cover property (@(posedge mclk) $rose(busOe_q));
  c_vbus:     cover property (@(posedge mclk) $rose(lowPwrOe_q));
  c_rst_met:  cover property (@(posedge mclk) $rose(rstTimeMet_q));
  c_cmd_done: cover property (@(posedge mclk) $fell(cmdBusy_q));
endmodule // apt_port_ctrl

// File: dv/apt_drive_model.sv
// Purpose: drive-side partner of the port control, pins and register writes
// Assumes: one register write is taken per cycle with devReady high
// Notes:   slow mode raises devReady one cycle in three to stretch commands
`timescale 1ns/10ps
module apt_drive_model
  import apt_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // pacing and pins seen from the drive
  input  wire logic        slow,
  input  wire apt_dev_wr_t devWr,
  input  wire logic        lowPwrOe,
  input  wire logic        highPwrOe,
  input  wire logic        driveRstOut,
  input  wire logic        driveRstOe,
  input  wire logic        driveRstPd,
  output logic             devReady,
  output logic             lowPwrPin,
  output logic             highPwrPin,
  output logic             driveRstPin
);
  logic [1:0]  paceQ;
  logic [18:0] got[$];
  // ************************************************
  // pacing and capture
  // ************************************************
  always @(posedge mclk) begin
    paceQ    <= (!nrst || paceQ == 2'h2) ? 2'h0 : paceQ + 2'h1;
    devReady <= nrst && (!slow || paceQ == 2'h0);
    if (nrst && devWr.wr === 1'b1) begin
      got.push_back({devWr.addr, devWr.data});
    end
  end
  // external pullups on the open-drain lines, no drive means high
  assign lowPwrPin   = lowPwrOe ? 1'b0 : 1'b1;
  assign highPwrPin  = highPwrOe ? 1'b0 : 1'b1;
  // an undriven reset line sits at its pulldown, else shows the inverse
  assign driveRstPin = driveRstOe ? driveRstOut : (driveRstPd ? 1'b0 : ~driveRstOut);
endmodule // apt_drive_model

// File: dv/test_ata_port_power_tristate_ctrl.sv
// Purpose: self-checking bench of the drive port power and 3-state control
// Assumes: strobes driven by nba at the rising edge, checks 1 ns later
// Notes:   expected command writes are rebuilt here from the task file
`timescale 1ns/10ps
`include "apt_defines.svh"
module test_ata_port_power_tristate_ctrl;
  import apt_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, vbusPin = 1'b0, slow = 1'b0;
  logic busDisWr = 1'b0, busDisVal = 1'b0, hardRstWr = 1'b0, hardRstVal = 1'b0;
  logic bootDone = 1'b0, fwLowPwrWr = 1'b0, fwLowPwrVal = 1'b0;
  logic fwHighPwrWr = 1'b0, fwHighPwrVal = 1'b0, cmdStart = 1'b0, isPacket = 1'b0;
  logic cswPrepare = 1'b0, devReady;
  apt_scheme_t    scheme = SCH_MANUAL;
  logic [4:0]     cbLen = 5'h01;
  apt_task_file_t taskFile = '0;
  logic [31:0]    cbwTag = '0, expectedLen = '0, processedLen = '0, seed;
  logic busOe_q, busPulldown_q, driveRstOut_q, driveRstOe_q, driveRstPd_q, lowPwrOut_q;
  logic lowPwrOe_q, highPwrOut_q, highPwrOe_q, cmdBusy_q, cmdLenErr_q, dataAutoEn_q;
  logic cswValid_q, busDisable_q, hardReset_q, orderErr_q, rstTimeMet_q;
  logic lowPwrPin, highPwrPin, driveRstPin;
  apt_dev_wr_t devWr_q;
  apt_csw_t    csw_q;
  logic [18:0] expQ[$];
  int fail_count = 0, check_count = 0, cswCount = 0, preps = 0, n, i;
  int ataOrd[7] = '{6, 1, 2, 3, 4, 5, 7};

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (cswValid_q === 1'b1) cswCount++;

  apt_port_ctrl i_dut (.mclk(mclk), .nrst(nrst), .vbusPin(vbusPin), .busDisWr(busDisWr),
    .busDisVal(busDisVal), .hardRstWr(hardRstWr), .hardRstVal(hardRstVal),
    .bootDone(bootDone), .fwLowPwrWr(fwLowPwrWr), .fwLowPwrVal(fwLowPwrVal),
    .fwHighPwrWr(fwHighPwrWr), .fwHighPwrVal(fwHighPwrVal), .scheme(scheme),
    .cmdStart(cmdStart), .isPacket(isPacket), .cbLen(cbLen), .taskFile(taskFile),
    .devReady(devReady), .cswPrepare(cswPrepare), .cbwTag(cbwTag),
    .expectedLen(expectedLen), .processedLen(processedLen), .busOe_q(busOe_q),
    .busPulldown_q(busPulldown_q), .driveRstOut_q(driveRstOut_q),
    .driveRstOe_q(driveRstOe_q), .driveRstPd_q(driveRstPd_q), .lowPwrOut_q(lowPwrOut_q),
    .lowPwrOe_q(lowPwrOe_q), .highPwrOut_q(highPwrOut_q), .highPwrOe_q(highPwrOe_q),
    .devWr_q(devWr_q), .cmdBusy_q(cmdBusy_q), .cmdLenErr_q(cmdLenErr_q),
    .dataAutoEn_q(dataAutoEn_q), .csw_q(csw_q), .cswValid_q(cswValid_q),
    .busDisable_q(busDisable_q), .hardReset_q(hardReset_q), .orderErr_q(orderErr_q),
    .rstTimeMet_q(rstTimeMet_q));
  apt_drive_model i_drv (.mclk(mclk), .nrst(nrst), .slow(slow), .devWr(devWr_q),
    .lowPwrOe(lowPwrOe_q), .highPwrOe(highPwrOe_q), .driveRstOut(driveRstOut_q),
    .driveRstOe(driveRstOe_q), .driveRstPd(driveRstPd_q), .devReady(devReady),
    .lowPwrPin(lowPwrPin), .highPwrPin(highPwrPin), .driveRstPin(driveRstPin));

  // ************************************************
  // shared tasks
  // ************************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic pick(input int idx);
    case (idx)
      0: return busOe_q;
      1: return driveRstOut_q;
      2: return lowPwrOe_q;
      3: return highPwrOe_q;
      4: return cmdBusy_q;
      5: return rstTimeMet_q;
      default: return cswValid_q;
    endcase
  endfunction

  // bounded wait, a lapse ends the run as a mismatch
  task automatic wait_sig(input int idx, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(idx) !== v && cnt < lim) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
    if (pick(idx) !== v) begin
      fail_count++;
      $display("mismatch at %0t: wait on %0d ran out", $time, idx);
      report_and_stop();
    end
  endtask

  // one-cycle write strobe: 0 bus disable, 1 hard reset, 2 low, 3 high, 4 boot done
  task automatic strobe(input int which, input logic v);
    @(posedge mclk);
    case (which)
      0: begin busDisWr <= 1'b1; busDisVal <= v; end
      1: begin hardRstWr <= 1'b1; hardRstVal <= v; end
      2: begin fwLowPwrWr <= 1'b1; fwLowPwrVal <= v; end
      3: begin fwHighPwrWr <= 1'b1; fwHighPwrVal <= v; end
      default: bootDone <= 1'b1;
    endcase
    @(posedge mclk);
    {busDisWr, hardRstWr, fwLowPwrWr, fwHighPwrWr, bootDone} <= 5'h00;
    #1;
  endtask

  // mode 0 runs, 1 refused for length, 2 ignored
  task automatic run_cmd(input logic pkt, input logic [4:0] len, input int mode);
    int k;
    i_drv.got.delete();
    // task file written at the caller's edge has settled only from here
    @(posedge mclk);
    expQ.delete();
    if (pkt) begin
      expQ.push_back({`APT_REG_CMD, 8'h00, `APT_PKT_CMD});
      for (k = 0; k < (len + 1) / 2; k++) expQ.push_back({`APT_REG_DATA, taskFile[2*k+1], taskFile[2*k]});
    end else begin
      for (k = 0; k < 7; k++) expQ.push_back({3'(ataOrd[k]), 8'h00, taskFile[ataOrd[k]]});
    end
    if (mode != 0) expQ.delete();
    isPacket <= pkt;
    cbLen    <= len;
    cmdStart <= 1'b1;
    @(posedge mclk);
    cmdStart <= 1'b0;
    #1;
    if (mode == 0) begin
      wait_sig(4, 1'b1, 4, k);
      wait_sig(4, 1'b0, 300, k);
      // the last write leaves with busy falling; the drive takes it one edge later
      @(posedge mclk);
      #1;
    end else begin
      repeat (4) @(posedge mclk);
      #1;
      chk(cmdBusy_q, 1'b0, "busy on refused start");
      chk(cmdLenErr_q, mode == 1, "length error flag");
    end
    chk(i_drv.got.size(), expQ.size(), "write count");
    for (k = 0; k < expQ.size() && k < i_drv.got.size(); k++) chk(i_drv.got[k], expQ[k], "write");
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    seed = 32'h840f634e;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    chk(busOe_q, 1'b0, "bus driven after reset");
    chk(busPulldown_q, 1'b1, "pulldowns after reset");
    chk({driveRstOe_q, driveRstPd_q, driveRstPin}, 3'h2, "reset line after reset");
    chk({lowPwrOe_q, highPwrOe_q, lowPwrPin, highPwrPin}, 4'h3, "power lines");
    chk({lowPwrOut_q, highPwrOut_q}, 2'h0, "open-drain levels");
    chk(busDisable_q, 1'b1, "bus disable bit");
    @(posedge mclk) vbusPin <= 1'b1;
    wait_sig(2, 1'b1, 12, n);
    chk(lowPwrPin, 1'b0, "low power pin");
    strobe(2, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(lowPwrOe_q, 1'b1, "boot drive kept against firmware");
    chk(highPwrOe_q, 1'b0, "high power untouched by hardware");
    strobe(4, 1'b1);
    strobe(3, 1'b1);
    wait_sig(3, 1'b1, 4, n);
    strobe(3, 1'b0);
    wait_sig(3, 1'b0, 4, n);
    // power-up order: hard reset, enable bus, wait, release
    strobe(1, 1'b1);
    wait_sig(1, 1'b0, 4, n);
    chk(busOe_q, 1'b0, "bus still off");
    strobe(0, 1'b0);
    wait_sig(0, 1'b1, 4, n);
    chk({busPulldown_q, driveRstOe_q, rstTimeMet_q}, 3'h2, "bus enabled");
    wait_sig(5, 1'b1, `APT_RST_CYC + 8, n);
    chk(n >= `APT_RST_CYC - 4, 1'b1, "reset duration too short");
    chk(orderErr_q, 1'b0, "order error on legal order");
    strobe(1, 1'b0);
    wait_sig(1, 1'b1, 4, n);
    // only the automatic scheme starts hardware command writes
    for (i = 0; i < 2; i++) begin
      @(posedge mclk) scheme <= (i == 0) ? SCH_MANUAL : SCH_SEMI;
      run_cmd(1'b0, 5'h0c, 2);
      chk(dataAutoEn_q, i == 1, "data stage automation");
    end
    @(posedge mclk) scheme <= SCH_AUTO;
    for (i = 0; i < 14; i++) begin
      @(posedge mclk);
      slow <= i[0];
      for (n = 0; n < 16; n++) taskFile[n] <= 8'($random(seed));
      case (i)
        0: run_cmd(1'b1, 5'h01, 0);
        1: run_cmd(1'b1, 5'h10, 0);
        2: run_cmd(i[1], 5'h00, 1);
        3: run_cmd(i[1], 5'h11, 1);
        default: run_cmd(1'($random(seed)), 5'(($random(seed) & 15) + 1), 0);
      endcase
    end
    // status stage comes only from firmware
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      cbwTag       <= $random(seed);
      expectedLen  <= $random(seed);
      processedLen <= (i == 0) ? 32'h0 : $random(seed);
      cswPrepare   <= 1'b1;
      @(posedge mclk);
      cswPrepare <= 1'b0;
      preps++;
      #1;
      wait_sig(6, 1'b1, 3, n);
      chk(csw_q.tag, cbwTag, "status tag");
      chk(csw_q.residue, expectedLen - processedLen, "status residue");
      @(posedge mclk);
      #1;
      chk(cswValid_q, 1'b0, "status valid one cycle");
    end
    chk(cswCount, preps, "status stages without firmware");
    strobe(0, 1'b1);
    wait_sig(0, 1'b0, 4, n);
    chk(busPulldown_q, 1'b1, "pulldowns when disabled");
    run_cmd(1'b0, 5'h0c, 2);
    // second reset without vbus
    @(posedge mclk);
    nrst    <= 1'b0;
    vbusPin <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    chk(lowPwrOe_q, 1'b0, "low power driven without vbus");
    strobe(4, 1'b1);
    strobe(2, 1'b1);
    wait_sig(2, 1'b1, 4, n);
    strobe(3, 1'b1);
    wait_sig(3, 1'b1, 4, n);
    // enabling the bus with no hard reset first is an order slip
    strobe(0, 1'b0);
    chk({orderErr_q, hardReset_q}, 2'h2, "order slip not flagged");
    report_and_stop();
  end
endmodule // test_ata_port_power_tristate_ctrl
